// [pmon_regs_pkg.sv]
package pmon_regs_pkg;

  // ************************************************************
  // Register indexes (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_RANGE_PROG   = 6'h1D;
  localparam logic [5:0] IDX_RANGE_LATCH  = 6'h24;
  localparam logic [5:0] IDX_ACCUM_SRC    = 6'h25;
  localparam logic [5:0] IDX_ALERT_STATUS = 6'h26;
  localparam logic [5:0] IDX_ALERT_ENABLE = 6'h30;
  localparam logic [5:0] IDX_COMMAND      = 6'h31;
  localparam logic [5:0] IDX_IRQ_STATUS   = 6'h32;
  localparam logic [5:0] IDX_IRQ_MASK     = 6'h33;
  localparam logic [5:0] IDX_ACTIVE_RANGE = 6'h34;
  localparam int         ADDR_W           = 8;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int          SENSE_RANGE_LSB   = 8;
  localparam int          BUS_RANGE_LSB     = 0;
  localparam int          COND_LSB          = 4;
  localparam int          ACCUM_OVERFLOW_FLAG_BIT       = 3;
  localparam int          ACC_TALLY_BIT     = 2;
  localparam logic [23:0] ALERT_IMPL_MASK   = 24'hFFFFFC;
  localparam logic [15:0] RANGE_RESET       = 16'h0000;
  localparam logic [7:0]  ACCUM_SRC_RESET   = 8'h00;
  localparam logic [19:0] ALERT_EN_RESET    = 20'h00000;
  localparam logic [1:0]  ACC_SRC_RESERVED  = 2'h3;
  localparam int          CMD_REFRESH_BIT   = 0;
  localparam int          IRQ_ALERT_BIT     = 0;
  localparam int          IRQ_LATCH_BIT     = 1;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int SETTLE_NS      = 1000000;
  localparam int CLK_PERIOD_NS  = 5;
  localparam int SETTLE_CYCLES  = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W       = 18;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic [19:0] limit;
    logic        accum_full;
    logic        tally_full;
  } alert_cond_t;

endpackage

// [pmon_regs.sv]
`timescale 1ns/1ps
module pmon_regs
  import pmon_regs_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_CYCLES
)
(
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  // Register bus
  input  wire pmon_regs_pkg::axil_req_t  AXI_REQ,
  output      pmon_regs_pkg::axil_rsp_t  AXI_RSP,
  // Measurement engine
  input  wire logic                      CONV_DONE,
  input  wire pmon_regs_pkg::alert_cond_t ALERT_COND,
  output      logic [15:0]               ACTIVE_RANGE,
  output      logic [7:0]                ACCUM_SOURCE,
  output      logic                      RESULTS_VALID,
  // Interrupt
  output      logic                      IRQ
);
  import pmon_regs_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    axil_rsp_t         rsp;
    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic [15:0]       range_prog;
    logic [15:0]       range_active;
    logic [15:0]       range_stage;
    logic [15:0]       range_latch;
    logic              latch_valid;
    logic              refresh_pending;
    logic [SETTLE_W-1:0] settle_cnt;
    logic [7:0]        accum_src;
    logic [19:0]       alert_en;
    logic [23:0]       alert_flags;
    logic [23:0]       clear_pend;
    logic [1:0]        irq_status;
    logic [1:0]        irq_mask;
    logic              irq;
  } state_t;

  localparam state_t STATE_RESET = '{
    rsp:             '0,
    aw_have:         1'b0,
    w_have:          1'b0,
    aw_addr:         '0,
    w_data:          32'h00000000,
    w_strb:          4'h0,
    range_prog:      RANGE_RESET,
    range_active:    RANGE_RESET,
    range_stage:     RANGE_RESET,
    range_latch:     RANGE_RESET,
    latch_valid:     1'b0,
    refresh_pending: 1'b0,
    settle_cnt:      '0,
    accum_src:       ACCUM_SRC_RESET,
    alert_en:        ALERT_EN_RESET,
    alert_flags:     24'h000000,
    clear_pend:      24'h000000,
    irq_status:      2'h0,
    irq_mask:        2'h0,
    irq:             1'b0
  };

  state_t state_r;
  state_t state_nxt;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Reserved selector is folded to power so the engine never sees it
  function automatic logic [7:0] clean_accum(input logic [7:0] v);
    logic [7:0] res;
    res = v;
    for (int c = 0; c < 4; c++)
    begin
      if (v[c*2 +: 2] == ACC_SRC_RESERVED)
      begin
        res[c*2 +: 2] = 2'h0;
      end
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [5:0] idx);
    return (idx == IDX_RANGE_PROG) || (idx == IDX_RANGE_LATCH) ||
           (idx == IDX_ACCUM_SRC) || (idx == IDX_ALERT_STATUS) ||
           (idx == IDX_ALERT_ENABLE) || (idx == IDX_COMMAND) ||
           (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK) ||
           (idx == IDX_ACTIVE_RANGE);
  endfunction

  function automatic logic [31:0] read_mux(input state_t s, input logic [5:0] idx);
    logic [31:0] res;
    res = 32'h00000000;
    unique case (idx)
      IDX_RANGE_PROG:   res = {16'h0000, s.range_prog};
      IDX_RANGE_LATCH:  res = {16'h0000, s.range_latch};
      IDX_ACCUM_SRC:    res = {24'h000000, s.accum_src};
      IDX_ALERT_STATUS: res = {8'h00, s.alert_flags & ALERT_IMPL_MASK};
      IDX_ALERT_ENABLE: res = {8'h00, s.alert_en, 4'h0};
      IDX_COMMAND:      res = {31'h00000000, s.refresh_pending};
      IDX_IRQ_STATUS:   res = {30'h00000000, s.irq_status};
      IDX_IRQ_MASK:     res = {30'h00000000, s.irq_mask};
      IDX_ACTIVE_RANGE: res = {16'h0000, s.range_active};
      default:          res = 32'h00000000;
    endcase
    return res;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  logic              aw_take;
  logic              w_take;
  logic              do_write;
  logic              rd_take;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [5:0]        wr_idx;
  logic [5:0]        rd_idx;
  logic [31:0]       wr_word;
  logic              refresh_cmd;
  logic              latch_load;
  logic [23:0]       alert_set;
  logic [1:0]        irq_event;

  always_comb
  begin
    state_nxt = state_r;

    // Bus handshakes
    aw_take  = AXI_REQ.awvalid & state_r.rsp.awready;
    w_take   = AXI_REQ.wvalid & state_r.rsp.wready;
    rd_take  = AXI_REQ.arvalid & state_r.rsp.arready;
    wr_addr  = aw_take ? AXI_REQ.awaddr : state_r.aw_addr;
    wr_data  = w_take ? AXI_REQ.wdata : state_r.w_data;
    wr_strb  = w_take ? AXI_REQ.wstrb : state_r.w_strb;
    wr_idx   = wr_addr[7:2];
    rd_idx   = AXI_REQ.araddr[7:2];
    do_write = (state_r.aw_have | aw_take) & (state_r.w_have | w_take);
    if (aw_take)
    begin
      state_nxt.aw_addr = AXI_REQ.awaddr;
    end
    if (w_take)
    begin
      state_nxt.w_data = AXI_REQ.wdata;
      state_nxt.w_strb = AXI_REQ.wstrb;
    end
    state_nxt.aw_have = (state_r.aw_have | aw_take) & ~do_write;
    state_nxt.w_have  = (state_r.w_have | w_take) & ~do_write;

    // Register writes
    wr_word     = 32'h00000000;
    refresh_cmd = 1'b0;
    if (do_write)
    begin
      state_nxt.rsp.bresp = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      unique case (wr_idx)
        IDX_RANGE_PROG:
        begin
          wr_word = merge_strb({16'h0000, state_r.range_prog}, wr_data, wr_strb);
          state_nxt.range_prog = wr_word[15:0];
        end
        IDX_RANGE_LATCH:
        begin
          wr_word = merge_strb({16'h0000, state_r.range_latch}, wr_data, wr_strb);
          state_nxt.range_latch = wr_word[15:0];
        end
        IDX_ACCUM_SRC:
        begin
          wr_word = merge_strb({24'h000000, state_r.accum_src}, wr_data, wr_strb);
          state_nxt.accum_src = clean_accum(wr_word[7:0]);
        end
        IDX_ALERT_ENABLE:
        begin
          wr_word = merge_strb({8'h00, state_r.alert_en, 4'h0}, wr_data, wr_strb);
          state_nxt.alert_en = wr_word[23:4];
        end
        IDX_COMMAND:      refresh_cmd = wr_strb[0] & wr_data[CMD_REFRESH_BIT];
        IDX_IRQ_MASK:
        begin
          wr_word = merge_strb({30'h00000000, state_r.irq_mask}, wr_data, wr_strb);
          state_nxt.irq_mask = wr_word[1:0];
        end
        default:          wr_word = 32'h00000000;
      endcase
    end

    // Write channel handshake; one write in flight at a time
    state_nxt.rsp.bvalid  = do_write | (state_r.rsp.bvalid & ~AXI_REQ.bready);
    state_nxt.rsp.awready = ~state_nxt.aw_have & ~state_nxt.rsp.bvalid;
    state_nxt.rsp.wready  = ~state_nxt.w_have & ~state_nxt.rsp.bvalid;

    // Refresh: activate pending ranges, stage the ones they replace
    latch_load = state_r.refresh_pending && (state_r.settle_cnt == SETTLE_W'(1));
    if (refresh_cmd)
    begin
      state_nxt.range_stage     = state_r.range_active;
      state_nxt.range_active    = state_r.range_prog;
      state_nxt.refresh_pending = 1'b1;
      state_nxt.latch_valid     = 1'b0;
      state_nxt.settle_cnt      = SETTLE_W'(SETTLE_COUNT);
    end
    else if (latch_load)
    begin
      state_nxt.range_latch     = state_r.range_stage;
      state_nxt.latch_valid     = 1'b1;
      state_nxt.refresh_pending = 1'b0;
      state_nxt.settle_cnt      = '0;
    end
    else if (state_r.refresh_pending)
    begin
      state_nxt.settle_cnt = state_r.settle_cnt - SETTLE_W'(1);
    end

    // Alert flags: set at conversion end, no refresh needed
    alert_set = 24'h000000;
    if (CONV_DONE)
    begin
      alert_set[23:COND_LSB]  = ALERT_COND.limit & state_r.alert_en;
      alert_set[ACCUM_OVERFLOW_FLAG_BIT]   = ALERT_COND.accum_full;
      alert_set[ACC_TALLY_BIT] = ALERT_COND.tally_full;
      // Read flags drop here unless the cause is still present
      state_nxt.alert_flags = ((state_r.alert_flags & ~state_r.clear_pend) | alert_set)
                              & ALERT_IMPL_MASK;
      state_nxt.clear_pend  = 24'h000000;
    end
    if (rd_take && rd_idx == IDX_ALERT_STATUS)
    begin
      // A read arms the clear for the following conversion end
      state_nxt.clear_pend = state_nxt.clear_pend | state_r.alert_flags;
    end

    // Interrupt status: read clears, a new event wins
    irq_event = 2'h0;
    irq_event[IRQ_ALERT_BIT] = |(alert_set & ~state_r.alert_flags);
    irq_event[IRQ_LATCH_BIT] = latch_load & ~refresh_cmd;
    state_nxt.irq_status = (rd_take && rd_idx == IDX_IRQ_STATUS) ? irq_event
                                                                  : state_r.irq_status | irq_event;
    state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_mask);

    // Read channel; data sampled at the address edge
    if (rd_take)
    begin
      state_nxt.rsp.rdata = read_mux(state_r, rd_idx);
      state_nxt.rsp.rresp = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    state_nxt.rsp.rvalid  = rd_take | (state_r.rsp.rvalid & ~AXI_REQ.rready);
    state_nxt.rsp.arready = ~state_nxt.rsp.rvalid;
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      state_r <= STATE_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign AXI_RSP       = state_r.rsp;
  assign ACTIVE_RANGE  = state_r.range_active;
  assign ACCUM_SOURCE  = state_r.accum_src;
  assign RESULTS_VALID = state_r.latch_valid;
  assign IRQ           = state_r.irq;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_refresh;
    refresh_cmd;
  endsequence

  sequence s_status_read;
    rd_take && rd_idx == IDX_ALERT_STATUS && !CONV_DONE;
  endsequence

  chk_range_pending: assert property (
    @(posedge CLK) disable iff (RESET)
    $changed(state_r.range_active) |-> $past(refresh_cmd))
    else $error("active range changed without refresh");

  chk_latch_stage: assert property (
    @(posedge CLK) disable iff (RESET)
    s_refresh |=> state_r.range_stage == $past(state_r.range_active)
                  && state_r.range_active == $past(state_r.range_prog))
    else $error("refresh did not stage prior ranges");

  chk_latch_settle: assert property (
    @(posedge CLK) disable iff (RESET)
    (state_r.refresh_pending && !refresh_cmd && state_r.settle_cnt > SETTLE_W'(1))
    |=> state_r.settle_cnt == $past(state_r.settle_cnt) - SETTLE_W'(1)
        && !state_r.latch_valid)
    else $error("settle count not counting down");

  chk_latch_load: assert property (
    @(posedge CLK) disable iff (RESET)
    (latch_load && !refresh_cmd)
    |=> state_r.latch_valid && state_r.range_latch == $past(state_r.range_stage))
    else $error("latched ranges not loaded after settle");

  chk_accum_reserved: assert property (
    @(posedge CLK) disable iff (RESET)
    (do_write && wr_idx == IDX_ACCUM_SRC)
    |=> state_r.accum_src == clean_accum($past(wr_word[7:0])) &&
        (state_r.accum_src & (state_r.accum_src >> 1) & 8'h55) == 8'h00)
    else $error("reserved accumulator code kept");

  chk_alert_timing: assert property (
    @(posedge CLK) disable iff (RESET)
    !CONV_DONE |=> (state_r.alert_flags & ~$past(state_r.alert_flags)) == 24'h000000)
    else $error("alert flag set outside conversion end");

  chk_alert_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    s_status_read ##1 (!CONV_DONE)[*2]
    |=> (state_r.alert_flags & $past(state_r.alert_flags, 3)) ==
        $past(state_r.alert_flags, 3))
    else $error("alert flag cleared before conversion end");

  chk_alert_persist: assert property (
    @(posedge CLK) disable iff (RESET)
    (CONV_DONE && ALERT_COND.accum_full)
    ##1 (!CONV_DONE)[*1] |-> state_r.alert_flags[ACCUM_OVERFLOW_FLAG_BIT])
    else $error("persisting overflow flag lost");

  chk_alert_enable: assert property (
    @(posedge CLK) disable iff (RESET)
    (CONV_DONE && !state_r.rsp.rvalid && state_r.alert_en == 20'h00000
     && state_r.alert_flags[23:COND_LSB] == 20'h00000)
    |=> state_r.alert_flags[23:COND_LSB] == 20'h00000)
    else $error("disabled limit alert tripped");

  chk_unimpl_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    state_r.alert_flags[1:0] == 2'h0)
    else $error("unimplemented status bits set");

  chk_irq_level: assert property (
    @(posedge CLK) disable iff (RESET)
    ##1 IRQ == |($past(state_nxt.irq_status) & $past(state_nxt.irq_mask)))
    else $error("interrupt level mismatch");

endmodule

// [pmon_regs_bench.sv]
`timescale 1ns/1ps
module pmon_regs_bench
  import pmon_regs_pkg::*;
;
  localparam int SETTLE = 20;

  logic        clk;
  logic        reset;
  axil_req_t   req;
  axil_rsp_t   rsp;
  logic        conv_done;
  alert_cond_t cond;
  logic [15:0] active_range;
  logic [7:0]  accum_source;
  logic        results_valid;
  logic        irq;
  int          fail_count;
  int          n_checks;
  int          n;

  pmon_regs #(.SETTLE_COUNT(SETTLE)) dut_u
  (
    .CLK           (clk),
    .RESET         (reset),
    .AXI_REQ       (req),
    .AXI_RSP       (rsp),
    .CONV_DONE     (conv_done),
    .ALERT_COND    (cond),
    .ACTIVE_RANGE  (active_range),
    .ACCUM_SOURCE  (accum_source),
    .RESULTS_VALID (results_valid),
    .IRQ           (irq)
  );

  always #2.5 clk = ~clk;

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] data, input logic [1:0] eresp);
    int t;
    t = 0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= {idx, 2'b00};
    req.wvalid  <= 1'b1;
    req.wdata   <= data;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      t++;
    end while (rsp.bvalid !== 1'b1 && t < 200);
    chk({31'h0, rsp.bvalid}, 32'h1, "write answered");
    req.bready <= 1'b0;
    chk({30'h0, rsp.bresp}, {30'h0, eresp}, "write response");
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] data, output logic [1:0] resp);
    int t;
    t = 0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= {idx, 2'b00};
    req.rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      t++;
    end while (rsp.rvalid !== 1'b1 && t < 200);
    chk({31'h0, rsp.rvalid}, 32'h1, "read answered");
    data = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] eresp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk(d, exp, "read data");
    chk({30'h0, r}, {30'h0, eresp}, "read response");
  endtask

  // One conversion end; flags visible the cycle after
  task automatic conv(input logic [19:0] lim, input logic af, input logic tf);
    @(posedge clk);
    cond      <= '{limit: lim, accum_full: af, tally_full: tf};
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
  endtask

  task automatic refresh_wait();
    wr(IDX_COMMAND, 32'h0000_0001, RESP_OKAY);
    chk(32'(results_valid), 32'h0, "valid drops on refresh");
    n = 0;
    while (results_valid !== 1'b1 && n < 4 * SETTLE)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= SETTLE - 3 && n <= SETTLE), 32'h1, "settle length");
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    fail_count++;
    end_of_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    clk        = 1'b0;
    reset      = 1'b1;
    req        = '0;
    conv_done  = 1'b0;
    cond       = '0;
    fail_count = 0;
    n_checks   = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(IDX_RANGE_LATCH, 32'h0, RESP_OKAY);
    rd_chk(IDX_ACCUM_SRC, 32'h0, RESP_OKAY);
    rd_chk(IDX_ALERT_STATUS, 32'h0, RESP_OKAY);
    chk(32'(accum_source), 32'h0, "selector reset");
    // Codes 00,01,10,11 across the four fields, order reversed in the second write
    wr(IDX_ACCUM_SRC, 32'h0000_001B, RESP_OKAY);
    rd_chk(IDX_ACCUM_SRC, 32'h0000_0018, RESP_OKAY);
    chk(32'(accum_source), 32'h0000_0018, "selector port");
    wr(IDX_ACCUM_SRC, 32'h0000_00E4, RESP_OKAY);
    rd_chk(IDX_ACCUM_SRC, 32'h0000_0024, RESP_OKAY);
    // Range codes incl. reserved 11 in sense and bus fields
    wr(IDX_RANGE_PROG, 32'h0000_E5C3, RESP_OKAY);
    rd_chk(IDX_RANGE_PROG, 32'h0000_E5C3, RESP_OKAY);
    chk(32'(active_range), 32'h0, "range still pending");
    refresh_wait();
    chk(32'(active_range), 32'h0000_E5C3, "range now active");
    rd_chk(IDX_ACTIVE_RANGE, 32'h0000_E5C3, RESP_OKAY);
    rd_chk(IDX_RANGE_LATCH, 32'h0, RESP_OKAY);
    wr(IDX_RANGE_PROG, 32'h0000_1234, RESP_OKAY);
    refresh_wait();
    rd_chk(IDX_COMMAND, 32'h0, RESP_OKAY);
    rd_chk(IDX_RANGE_LATCH, 32'h0000_E5C3, RESP_OKAY);
    chk(32'(active_range), 32'h0000_1234, "second range active");
    wr(IDX_RANGE_LATCH, 32'h0000_5A5A, RESP_OKAY);
    rd_chk(IDX_RANGE_LATCH, 32'h0000_5A5A, RESP_OKAY);
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0002, RESP_OKAY);
    wr(IDX_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
    // Limits trip nothing until enabled
    conv(20'hFFFFF, 1'b0, 1'b0);
    rd_chk(IDX_ALERT_STATUS, 32'h0, RESP_OKAY);
    chk(32'(irq), 32'h0, "no irq without flags");
    wr(IDX_ALERT_ENABLE, 32'h00FF_FFF0, RESP_OKAY);
    rd_chk(IDX_ALERT_ENABLE, 32'h00FF_FFF0, RESP_OKAY);
    rd_chk(IDX_ALERT_STATUS, 32'h0, RESP_OKAY);
    conv(20'h80001, 1'b1, 1'b0);
    chk(32'(irq), 32'h1, "irq raised");
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
    chk(32'(irq), 32'h0, "irq cleared by read");
    wr(IDX_IRQ_MASK, 32'h0, RESP_OKAY);
    rd_chk(IDX_ALERT_STATUS, 32'h0080_0018, RESP_OKAY);
    rd_chk(IDX_ALERT_STATUS, 32'h0080_0018, RESP_OKAY);
    // Ch1 overcurrent persists, the other earlier flags go away, the tally flag sets
    conv(20'h80000, 1'b0, 1'b1);
    chk(32'(irq), 32'h0, "masked irq stays low");
    wr(IDX_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
    chk(32'(irq), 32'h1, "unmask shows pending");
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
    chk(32'(irq), 32'h0, "irq cleared again");
    rd_chk(IDX_ALERT_STATUS, 32'h0080_0004, RESP_OKAY);
    conv(20'h00000, 1'b0, 1'b0);
    wr(IDX_ALERT_STATUS, 32'h00FF_FFFF, RESP_OKAY);
    rd_chk(IDX_ALERT_STATUS, 32'h0, RESP_OKAY);
    // Unmapped places answer with an error
    rd_chk(6'h3F, 32'h0, RESP_SLVERR);
    wr(6'h3E, 32'hFFFF_FFFF, RESP_SLVERR);
    end_of_test();
  end
endmodule
